/* File: pchr_config_regs.sv */
`timescale 1ns/1ps
`include "pchr_defs.svh"
module pchr_config_regs #(
  parameter int LAT_WIDTH = 8
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // Configuration access
  input  wire logic        i_cfg_wr,
  input  wire logic        i_cfg_rd,
  input  wire logic [7:0]  i_cfg_addr,
  input  wire logic [3:0]  i_cfg_be,
  input  wire logic [31:0] i_cfg_wdata,
  output logic [31:0]      o_cfg_rdata,
  output logic             o_cfg_hit,
  // Command register enables
  input  wire logic        i_io_space_en,
  input  wire logic        i_mem_space_en,
  // Straps and eeprom word source
  input  wire logic        i_wake_connected,
  output logic             o_ee_req,
  output logic [5:0]       o_ee_word,
  input  wire logic        i_ee_valid,
  input  wire logic [15:0] i_ee_data,
  // Bus cycle address decode
  input  wire logic [31:0] i_bus_addr,
  input  wire logic        i_bus_is_io,
  output logic             o_csr_hit,
  output logic [7:0]       o_csr_offset,
  output logic             o_rom_hit,
  // Bus master burst control and identity load status
  input  wire logic        i_frame_start,
  input  wire logic        i_frame_active,
  input  wire logic        i_gnt_n,
  output logic             o_master_terminate,
  output logic [7:0]       o_cache_line_size,
  output logic             o_subsys_loaded
);
  import pchr_pkg::*;

  // Latency field is one byte lane wide, so no other width fits
  if (LAT_WIDTH != 8) begin : g_lat_width_check
    $error("pchr_config_regs LAT_WIDTH must be 8");
  end

  typedef struct packed {
    logic [7:0]  cache_line;
    logic [7:0]  lat_timer;
    logic [23:0] io_base;
    logic [24:0] mem_base;
    logic [20:0] rom_base;
    logic        rom_en;
    logic [31:0] subsys;
    logic [7:0]  cap_ptr;
    pchr_ld_t    ld_st;
    logic [31:0] rdata;
    logic        hit;
  } pchr_state_t;

  pchr_state_t s_q;
  pchr_state_t s_d;
  logic        expired;
  logic [31:0] wmask;

  pchr_lat_timer #(
    .WIDTH (LAT_WIDTH)
  ) u_lat (
    .i_clk          (i_clk),
    .i_rstn         (i_rstn),
    .i_load_val     (s_q.lat_timer),
    .i_frame_start  (i_frame_start),
    .i_frame_active (i_frame_active),
    .o_expired      (expired)
  );

  assign wmask = {{8{i_cfg_be[3]}}, {8{i_cfg_be[2]}}, {8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};

  always_comb begin
    logic [31:0] cur;
    logic [31:0] nv;
    cur = 32'h0000_0000;
    nv  = 32'h0000_0000;
    s_d = s_q;
    s_d.hit = 1'b0;
    // Config writes merge per byte lane
    case (i_cfg_addr)
      `PCHR_OFF_LAT_CACHE: cur = {16'h0000, s_q.lat_timer, s_q.cache_line};
      `PCHR_OFF_IO_BASE:   cur = {s_q.io_base, 8'h00};
      `PCHR_OFF_MEM_BASE:  cur = {s_q.mem_base, 7'h00};
      `PCHR_OFF_ROM_BASE:  cur = {s_q.rom_base, 10'h000, s_q.rom_en};
      default:             cur = 32'h0000_0000;
    endcase
    nv = (cur & ~wmask) | (i_cfg_wdata & wmask);
    if (i_cfg_wr) begin
      case (i_cfg_addr)
        `PCHR_OFF_LAT_CACHE: begin
          s_d.cache_line = nv[`PCHR_CACHE_LSB +: 8];
          s_d.lat_timer  = nv[`PCHR_LAT_LSB +: 8];
        end
        `PCHR_OFF_IO_BASE:  s_d.io_base  = nv[31:`PCHR_IO_BASE_LSB];
        `PCHR_OFF_MEM_BASE: s_d.mem_base = nv[31:`PCHR_MEM_BASE_LSB];
        `PCHR_OFF_ROM_BASE: begin
          s_d.rom_base = nv[31:`PCHR_ROM_BASE_LSB];
          s_d.rom_en   = nv[0];
        end
        default: s_d.hit = 1'b0; // Identity and pointer ignore writes
      endcase
    end
    if (i_cfg_rd) begin
      s_d.hit = 1'b1;
      case (i_cfg_addr)
        `PCHR_OFF_LAT_CACHE: s_d.rdata = {16'h0000, s_q.lat_timer, s_q.cache_line};
        `PCHR_OFF_IO_BASE:   s_d.rdata = {s_q.io_base, 7'h00, `PCHR_IO_IND};
        `PCHR_OFF_MEM_BASE:  s_d.rdata = {s_q.mem_base, 6'h00, `PCHR_MEM_IND};
        `PCHR_OFF_SUBSYS_ID: s_d.rdata = s_q.subsys;
        `PCHR_OFF_ROM_BASE:  s_d.rdata = {s_q.rom_base, 10'h000, s_q.rom_en};
        `PCHR_OFF_CAP_PTR:   s_d.rdata = {24'h000000, s_q.cap_ptr};
        default: begin
          s_d.rdata = 32'h0000_0000;
          s_d.hit   = 1'b0;
        end
      endcase
    end
    // Strap sampled while running, so it never feeds the reset value
    s_d.cap_ptr = i_wake_connected ? `PCHR_CAP_PTR_PM : `PCHR_CAP_PTR_NONE;
    // Eeprom fetch of the subsystem identity
    case (s_q.ld_st)
      PCHR_LD_IDLE: s_d.ld_st = PCHR_LD_VEN;
      PCHR_LD_VEN: begin
        if (i_ee_valid) begin
          s_d.subsys[15:0] = i_ee_data;
          s_d.ld_st        = PCHR_LD_SUB;
        end
      end
      PCHR_LD_SUB: begin
        if (i_ee_valid) begin
          s_d.subsys[31:16] = i_ee_data;
          s_d.ld_st         = PCHR_LD_DONE;
        end
      end
      PCHR_LD_DONE: s_d.ld_st = PCHR_LD_DONE;
      default:      s_d.ld_st = PCHR_LD_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Word address of the fetch in progress
  assign o_ee_req  = (s_q.ld_st == PCHR_LD_VEN) || (s_q.ld_st == PCHR_LD_SUB);
  assign o_ee_word = (s_q.ld_st == PCHR_LD_SUB) ? `PCHR_EE_SUBSYS_WORD : `PCHR_EE_SUBVEN_WORD;
  assign o_subsys_loaded = (s_q.ld_st == PCHR_LD_DONE);

  assign o_cfg_rdata       = s_q.rdata;
  assign o_cfg_hit         = s_q.hit;
  assign o_cache_line_size = s_q.cache_line;

  // Host register window decode; offsets are dword aligned
  logic io_match;
  logic mem_match;
  assign io_match  = i_bus_is_io && i_io_space_en &&
                     (i_bus_addr[31:`PCHR_IO_WIN_BITS] == s_q.io_base);
  assign mem_match = !i_bus_is_io && i_mem_space_en &&
                     (i_bus_addr[31:`PCHR_MEM_WIN_BITS] == s_q.mem_base);
  assign o_csr_hit    = (io_match || mem_match) && (i_bus_addr[1:0] == 2'b00);
  assign o_csr_offset = {i_bus_addr[7:2], 2'b00};

  assign o_rom_hit = !i_bus_is_io && s_q.rom_en && i_mem_space_en &&
                     (i_bus_addr[31:`PCHR_ROM_BASE_LSB] == s_q.rom_base);

  // Termination request once the timer ran out and grant is gone
  assign o_master_terminate = i_frame_active && expired && i_gnt_n;

  io_bit0_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ($past(i_cfg_rd) && $past(i_cfg_addr) == `PCHR_OFF_IO_BASE) |-> o_cfg_rdata[7:0] == 8'h01)
    else $error("Io base low byte wrong");

  mem_low_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ($past(i_cfg_rd) && $past(i_cfg_addr) == `PCHR_OFF_MEM_BASE) |-> o_cfg_rdata[6:0] == 7'h00)
    else $error("Memory base low bits not zero");

  mem_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_cfg_wr && i_cfg_addr == `PCHR_OFF_MEM_BASE && i_cfg_be == 4'hF && !i_cfg_rd)
      |=> s_q.mem_base == $past(i_cfg_wdata[31:7]))
    else $error("Memory base not stored");

  rom_gate_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_rom_hit |-> (s_q.rom_en && i_mem_space_en))
    else $error("Rom decoded while disabled");

  rom_low_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ($past(i_cfg_rd) && $past(i_cfg_addr) == `PCHR_OFF_ROM_BASE) |-> o_cfg_rdata[10:1] == 10'h000)
    else $error("Rom unused bits not zero");

  cap_ptr_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_wake_connected && $past(i_wake_connected) && $past(i_rstn))
      |-> s_q.cap_ptr == `PCHR_CAP_PTR_PM)
    else $error("Capability pointer wrong");

  subsys_ro_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (o_subsys_loaded && $past(o_subsys_loaded)) |-> $stable(s_q.subsys))
    else $error("Subsystem identity changed");

  subsys_load_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (s_q.ld_st == PCHR_LD_VEN && i_ee_valid) |=> (s_q.subsys[15:0] == $past(i_ee_data))
      ##0 (o_ee_word == `PCHR_EE_SUBSYS_WORD))
    else $error("Vendor word not loaded");

  term_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (expired && i_frame_active && i_gnt_n) |-> o_master_terminate)
    else $error("Termination missing after expiry");
endmodule

/* File: pchr_defs.svh */
`ifndef PCHR_DEFS_SVH
`define PCHR_DEFS_SVH
// Configuration offsets (byte addresses, word aligned)
`define PCHR_OFF_LAT_CACHE   8'h0C
`define PCHR_OFF_IO_BASE     8'h10
`define PCHR_OFF_MEM_BASE    8'h14
`define PCHR_OFF_SUBSYS_ID   8'h2C
`define PCHR_OFF_ROM_BASE    8'h30
`define PCHR_OFF_CAP_PTR     8'h34
// Field positions
`define PCHR_CACHE_LSB       0
`define PCHR_LAT_LSB         8
`define PCHR_IO_BASE_LSB     8
`define PCHR_MEM_BASE_LSB    7
`define PCHR_ROM_BASE_LSB    11
// Fixed read values
`define PCHR_IO_IND          1'b1
`define PCHR_MEM_IND         1'b0
`define PCHR_CAP_PTR_PM      8'h44
`define PCHR_CAP_PTR_NONE    8'h00
// Serial EEPROM word addresses for the subsystem identity
`define PCHR_EE_SUBVEN_WORD  6'h36
`define PCHR_EE_SUBSYS_WORD  6'h35
// Host control register window sizes (low address bits inside the window, not decoded by the bar)
`define PCHR_IO_WIN_BITS     8
`define PCHR_MEM_WIN_BITS    7
`endif

/* File: pchr_ee_model.sv */
`timescale 1ns/1ps
// Serial eeprom word source: answers each word request after a set delay
module pchr_ee_model (
  // Clock
  input  wire logic        i_clk,
  // Word request and contents
  input  wire logic        i_req,
  input  wire logic [5:0]  i_word,
  input  wire logic [1:0]  i_delay,
  input  wire logic [15:0] i_word36,
  input  wire logic [15:0] i_word35,
  // Answer
  output logic             o_valid,
  output logic [15:0]      o_data
);
  logic [1:0] cnt_q;
  initial begin
    cnt_q = 2'h0;
    o_valid = 1'b0;
    o_data = 16'h0;
  end
  always @(posedge i_clk) begin
    o_valid <= 1'b0;
    // Data wanders outside a valid pulse, so a stale word is never taken
    o_data <= ~o_data;
    if (i_req && !o_valid) begin
      if (cnt_q == i_delay) begin
        o_valid <= 1'b1;
        o_data <= (i_word == 6'h36) ? i_word36 : i_word35;
        cnt_q <= 2'h0;
      end else begin
        cnt_q <= cnt_q + 2'h1;
      end
    end
  end
endmodule

/* File: pchr_lat_timer.sv */
`timescale 1ns/1ps
`include "pchr_defs.svh"
// Master latency timer: loads on the frame start, counts down while frame is held.
module pchr_lat_timer #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  // Control
  input  wire logic [WIDTH-1:0] i_load_val,
  input  wire logic             i_frame_start,
  input  wire logic             i_frame_active,
  // Status
  output logic                  o_expired
);
  import pchr_pkg::*;

  // Refused at elaboration, so a bad width never reaches simulation
  if (WIDTH < 1 || WIDTH > 16) begin : g_width_check
    $error("pchr_lat_timer WIDTH out of range");
  end

  typedef struct packed {
    pchr_lt_t         st;
    logic [WIDTH-1:0] cnt;
  } pchr_lt_state_t;

  pchr_lt_state_t s_q;
  pchr_lt_state_t s_d;

  always_comb begin
    s_d = s_q;
    case (s_q.st)
      PCHR_LT_IDLE: begin
        if (i_frame_start) begin
          s_d.cnt = i_load_val;
          s_d.st  = (i_load_val == '0) ? PCHR_LT_EXPIRED : PCHR_LT_COUNT;
        end
      end
      PCHR_LT_COUNT: begin
        if (!i_frame_active) begin
          s_d.st = PCHR_LT_IDLE;
        end else if (s_q.cnt <= WIDTH'(1)) begin
          s_d.cnt = '0;
          s_d.st  = PCHR_LT_EXPIRED;
        end else begin
          s_d.cnt = s_q.cnt - WIDTH'(1);
        end
      end
      PCHR_LT_EXPIRED: begin
        if (!i_frame_active) s_d.st = PCHR_LT_IDLE;
      end
      default: s_d.st = PCHR_LT_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      s_q <= '{st: PCHR_LT_IDLE, cnt: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_expired = (s_q.st == PCHR_LT_EXPIRED);

  lt_idle_drop_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (s_q.st == PCHR_LT_COUNT && !i_frame_active) |=> !o_expired)
    else $error("Timer expired after frame released");

  lt_load_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (s_q.st == PCHR_LT_IDLE && i_frame_start && i_load_val > WIDTH'(1))
      |=> (s_q.cnt == $past(i_load_val)) && !o_expired)
    else $error("Timer did not load on frame start");
endmodule

/* File: pchr_pkg.sv */
package pchr_pkg;
  typedef enum logic [1:0] {
    PCHR_LD_IDLE = 2'b00,
    PCHR_LD_VEN  = 2'b01,
    PCHR_LD_SUB  = 2'b10,
    PCHR_LD_DONE = 2'b11
  } pchr_ld_t;
  typedef enum logic [1:0] {
    PCHR_LT_IDLE    = 2'b00,
    PCHR_LT_COUNT   = 2'b01,
    PCHR_LT_EXPIRED = 2'b10
  } pchr_lt_t;
endpackage

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic        i_clk = 1'b0, i_rstn = 1'b0;
  logic        wr = 1'b0, rd = 1'b0, io_en = 1'b0, mem_en = 1'b0, wake = 1'b1;
  logic [7:0]  addr = 8'h00, csr_off, cls;
  logic [3:0]  be = 4'h0;
  logic [31:0] wdata = 32'h0, bus_addr = 32'h0, rdata, v, io_b, mem_b, rom_b;
  logic        is_io = 1'b0, fstart = 1'b0, factive = 1'b0, gnt_n = 1'b1;
  logic        hit, ee_req, ee_valid, csr_hit, rom_hit, term, loaded, rd_q = 1'b0;
  logic [5:0]  ee_word;
  logic [15:0] ee_data, w36 = 16'h0, w35 = 16'h0;
  logic [1:0]  dly = 2'h0;
  logic [32:0] exp_q[$];
  int          error_cnt = 0, samples_checked = 0, seed = 32'hf44a7f7c;
  always #5 i_clk = ~i_clk;
  pchr_config_regs DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_cfg_wr(wr), .i_cfg_rd(rd),
    .i_cfg_addr(addr), .i_cfg_be(be), .i_cfg_wdata(wdata), .o_cfg_rdata(rdata),
    .o_cfg_hit(hit), .i_io_space_en(io_en), .i_mem_space_en(mem_en),
    .i_wake_connected(wake), .o_ee_req(ee_req), .o_ee_word(ee_word),
    .i_ee_valid(ee_valid), .i_ee_data(ee_data), .i_bus_addr(bus_addr), .i_bus_is_io(is_io),
    .o_csr_hit(csr_hit), .o_csr_offset(csr_off), .o_rom_hit(rom_hit),
    .i_frame_start(fstart), .i_frame_active(factive), .i_gnt_n(gnt_n),
    .o_master_terminate(term), .o_cache_line_size(cls), .o_subsys_loaded(loaded));
  pchr_ee_model EE (.i_clk(i_clk), .i_req(ee_req), .i_word(ee_word), .i_delay(dly),
    .i_word36(w36), .i_word35(w35), .o_valid(ee_valid), .o_data(ee_data));
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checked=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Read results land one cycle after the strobe
  always @(posedge i_clk) rd_q <= rd;
  always @(negedge i_clk) if (rd_q && exp_q.size() > 0) chk({hit, rdata}, exp_q.pop_front());
  task automatic wr32(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge i_clk);
    wr = 1'b1; addr = a; be = b; wdata = d;
    @(negedge i_clk);
    wr = 1'b0;
  endtask
  task automatic rd32(input logic [7:0] a, input logic [32:0] e);
    @(negedge i_clk);
    rd = 1'b1; addr = a;
    exp_q.push_back(e);
    @(negedge i_clk);
    rd = 1'b0;
  endtask
  task automatic dec(input logic [2:0] m, input logic [31:0] a, input logic [1:0] e);
    @(negedge i_clk);
    {io_en, mem_en, is_io} = m; bus_addr = a;
    #1 chk({31'h0, csr_hit, rom_hit}, {31'h0, e});
  endtask
  task automatic wait_loaded;
    int n;
    n = 0;
    while (loaded !== 1'b1) begin
      @(negedge i_clk);
      n++;
      if (n > 200) begin
        error_cnt++;
        summarize();
      end
    end
  endtask
  initial begin
    // Second pass resets mid-run with a slow eeprom
    for (int p = 0; p < 2; p++) begin
      w36 = 16'($random(seed)); w35 = 16'($random(seed)); dly = 2'(p * 3);
      i_rstn = 1'b0;
      repeat (12) @(negedge i_clk);
      i_rstn = 1'b1;
      wait_loaded();
      rd32(8'h2C, {1'b1, w35, w36});
    end
    wr32(8'h2C, 4'hF, ~{w35, w36});
    wr32(8'h34, 4'hF, 32'hFFFFFFFF);
    rd32(8'h2C, {1'b1, w35, w36});
    rd32(8'h34, {1'b1, 32'h44});
    wake = 1'b0;
    rd32(8'h34, 33'h100000000);
    v = $random(seed) & 32'h0000FFFF;
    wr32(8'h0C, 4'hF, v);
    rd32(8'h0C, {1'b1, v});
    chk({25'h0, cls}, {25'h0, v[7:0]});
    wr32(8'h0C, 4'h2, 32'hFFFF04FF);
    rd32(8'h0C, {1'b1, 16'h0, 8'h04, v[7:0]});
    io_b = $random(seed);
    wr32(8'h10, 4'hF, io_b & 32'hFFFFFFFE);
    io_b = (io_b & 32'hFFFFFF00) | 32'h1;
    rd32(8'h10, {1'b1, io_b});
    mem_b = $random(seed) | 32'h1;
    wr32(8'h14, 4'hF, mem_b);
    mem_b &= 32'hFFFFFF80;
    rd32(8'h14, {1'b1, mem_b});
    rom_b = $random(seed) | 32'h7FF;
    wr32(8'h30, 4'hF, rom_b);
    rom_b &= 32'hFFFFF801;
    rd32(8'h30, {1'b1, rom_b});
    rd32(8'h38, 33'h0);
    dec(3'b101, {io_b[31:8], 8'hA8}, 2'b10);
    chk({25'h0, csr_off}, {25'h0, 8'hA8});
    // Not dword aligned: no host register answers
    dec(3'b101, {io_b[31:8], 8'hA9}, 2'b00);
    dec(3'b001, {io_b[31:8], 8'hA8}, 2'b00);
    dec(3'b010, {mem_b[31:7], 7'h44}, 2'b10);
    dec(3'b000, {mem_b[31:7], 7'h44}, 2'b00);
    dec(3'b010, {rom_b[31:11], 11'h123}, 2'b01);
    dec(3'b000, {rom_b[31:11], 11'h123}, 2'b00);
    wr32(8'h30, 4'hF, rom_b & 32'hFFFFFFFE);
    dec(3'b010, {rom_b[31:11], 11'h123}, 2'b00);
    // Latency value 4: expiry needs four edges of held frame
    @(negedge i_clk);
    fstart = 1'b1; factive = 1'b1;
    @(negedge i_clk) fstart = 1'b0;
    chk({32'h0, term}, 33'h0);
    @(negedge i_clk) factive = 1'b0;
    @(negedge i_clk) fstart = 1'b1; factive = 1'b1;
    @(negedge i_clk) fstart = 1'b0;
    chk({32'h0, term}, 33'h0);
    repeat (5) @(negedge i_clk);
    gnt_n = 1'b0;
    #1 chk({32'h0, term}, 33'h0);
    @(negedge i_clk) gnt_n = 1'b1;
    #1 chk({32'h0, term}, 33'h1);
    factive = 1'b0;
    repeat (3) @(negedge i_clk);
    summarize();
  end
endmodule
